/* hdl/cmpl_top.sv */
// Comparator output digital control and latch reset source selection.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "cmpl_defines.svh"

module cmpl_top #(
  parameter int NUM_CMP = 2
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Analog comparator raw decisions, asynchronous to the clock.
  input wire logic [1:0] cmp_raw_i,
  // Port direction bits of the two output pins.
  input wire logic [1:0] pin_direction_bit_i,
  // Latch reset sources and timer clock, asynchronous.
  input wire logic latch_peripheral_input_pin_i,
  input wire logic latch_divided_clock_i,
  input wire logic timer_clk_i,
  // Pin outputs.
  output logic [1:0] cmp_pin_o,
  output logic [1:0] cmp_pin_oe_o,
  // Analog controls.
  output logic [1:0] cmp_power_on_o,
  output logic [1:0] cmp_speed_o,
  output logic [1:0] cmp_hyst_o,
  output logic [3:0] cmp_pch_o,
  output logic [3:0] cmp_nch_o,
  // Sampled outputs for internal consumers.
  output logic [1:0] cmp_sampled_o,
  output logic [1:0] cmp_timer_sync_o,
  // Latch reset and interrupt.
  output logic latch_reset_o,
  output logic irq_o
);

  // Control registers, one pair per comparator.
  cmpl_pkg::cmpl_byte_t ctrl_first [NUM_CMP];
  cmpl_pkg::cmpl_byte_t ctrl_second [NUM_CMP];
  cmpl_pkg::cmpl_byte_t next_ctrl_first [NUM_CMP];
  cmpl_pkg::cmpl_byte_t next_ctrl_second [NUM_CMP];
  cmpl_pkg::cmpl_byte_t latch_control_zero;
  cmpl_pkg::cmpl_byte_t latch_control_one;
  cmpl_pkg::cmpl_byte_t next_latch_control_zero;
  cmpl_pkg::cmpl_byte_t next_latch_control_one;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic [1:0] next_irq_status;
  logic [1:0] next_irq_enable;
  logic [7:0] next_rdata;

  // Three-stage synchronisers for every asynchronous input.
  logic [2:0] s_raw0, s_raw1, s_pin, s_dclk, s_tclk;
  logic [2:0] s_dir0, s_dir1;
  logic [1:0] raw_f, dir_f;
  logic [1:0] next_raw_f, next_dir_f;
  logic pin_f, dclk_f, tclk_f, tclk_prev;
  logic next_pin_f, next_dclk_f, next_tclk_f;

  // Pipeline of comparator results.
  logic [1:0] result;
  logic [1:0] result_q;
  logic [1:0] sampled;
  logic [1:0] next_sampled;
  logic [1:0] tsync;
  logic [1:0] next_tsync;
  logic [1:0] next_pin;
  logic [1:0] next_pin_oe;
  logic next_latch_reset;

  // Synchroniser shift registers; only the agreeing pair of stages 2 and 3 is used.
  // Direction stages reset to input, so no pin is driven until a cleared direction has
  // been seen on two agreeing stages after reset.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s_raw0 <= 3'h0;
      s_raw1 <= 3'h0;
      s_pin <= 3'h0;
      s_dclk <= 3'h0;
      s_tclk <= 3'h0;
      s_dir0 <= 3'h7;
      s_dir1 <= 3'h7;
    end else begin
      s_raw0 <= {s_raw0[1:0], cmp_raw_i[0]};
      s_raw1 <= {s_raw1[1:0], cmp_raw_i[1]};
      s_pin <= {s_pin[1:0], latch_peripheral_input_pin_i};
      s_dclk <= {s_dclk[1:0], latch_divided_clock_i};
      s_tclk <= {s_tclk[1:0], timer_clk_i};
      s_dir0 <= {s_dir0[1:0], pin_direction_bit_i[0]};
      s_dir1 <= {s_dir1[1:0], pin_direction_bit_i[1]};
    end
  end

  // A filtered level changes only once stages two and three agree, hiding one-cycle glitches.
  always_comb begin
    next_raw_f[0] = (s_raw0[2] == s_raw0[1]) ? s_raw0[2] : raw_f[0];
    next_raw_f[1] = (s_raw1[2] == s_raw1[1]) ? s_raw1[2] : raw_f[1];
    next_dir_f[0] = (s_dir0[2] == s_dir0[1]) ? s_dir0[2] : dir_f[0];
    next_dir_f[1] = (s_dir1[2] == s_dir1[1]) ? s_dir1[2] : dir_f[1];
    next_pin_f = (s_pin[2] == s_pin[1]) ? s_pin[2] : pin_f;
    next_dclk_f = (s_dclk[2] == s_dclk[1]) ? s_dclk[2] : dclk_f;
    next_tclk_f = (s_tclk[2] == s_tclk[1]) ? s_tclk[2] : tclk_f;
  end

  // Filtered input levels.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      raw_f <= 2'h0;
      dir_f <= 2'h3;
      pin_f <= 1'b0;
      dclk_f <= 1'b0;
      tclk_f <= 1'b0;
      tclk_prev <= 1'b0;
    end else begin
      raw_f <= next_raw_f;
      dir_f <= next_dir_f;
      pin_f <= next_pin_f;
      dclk_f <= next_dclk_f;
      tclk_f <= next_tclk_f;
      tclk_prev <= tclk_f;
    end
  end

  // Comparator result: the raw decision is high when positive input exceeds negative input.
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      // A disabled comparator reads low before polarity, so flipping polarity still moves it.
      result[i] = (raw_f[i] & ctrl_first[i][`CMPL_F1_ENABLE])
                  ^ ctrl_first[i][`CMPL_F1_POLARITY];
    end
  end

  // Per-cycle sample, timer-synchronised capture and pin drive for both comparators.
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      next_sampled[i] = result[i];
      // Capture on the falling edge of the timer clock so the timer never counts mid-change.
      next_tsync[i] = (tclk_prev & ~tclk_f) ? result[i] : tsync[i];
      next_pin[i] = ctrl_first[i][`CMPL_F1_SYNC] ? tsync[i] : result[i];
      // Enable and pin-output bits come from the values being written, so the pin drive
      // and the power control switch at the same edge and a comparator that is already
      // powered down never drives its pin.
      next_pin_oe[i] = next_ctrl_first[i][`CMPL_F1_PIN_OE] & ~dir_f[i]
                       & next_ctrl_first[i][`CMPL_F1_ENABLE];
    end
  end

  // Latch reset is the OR of every enabled source.
  // Every source is registered first, so the latch sees a clean level one cycle later
  // instead of a glitch from the asynchronous inputs.
  always_comb begin
    next_latch_reset = (latch_control_one[`CMPL_L1_PIN_RESET] & pin_f)
                     | (latch_control_one[`CMPL_L1_CLK_RESET] & dclk_f)
                     | (latch_control_one[`CMPL_L1_CMP2_RESET] & sampled[1])
                     | (latch_control_one[`CMPL_L1_CMP1_RESET] & sampled[0]);
  end

  // Result pipeline registers.
  // The previous sample feeds the edge detector; it resets low like the sample itself,
  // so the release from reset never looks like an edge.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      result_q <= 2'h0;
      sampled <= 2'h0;
      tsync <= 2'h0;
      cmp_pin_o <= 2'h0;
      cmp_pin_oe_o <= 2'h0;
      latch_reset_o <= 1'b0;
    end else begin
      result_q <= sampled;
      sampled <= next_sampled;
      tsync <= next_tsync;
      cmp_pin_o <= next_pin;
      cmp_pin_oe_o <= next_pin_oe;
      latch_reset_o <= next_latch_reset;
    end
  end

  // Register writes, edge interrupt flags and read data.
  // Unmapped indices are ignored on write and read back as zero, so software probing an
  // unused index causes no side effect.
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      next_ctrl_first[i] = ctrl_first[i];
      next_ctrl_second[i] = ctrl_second[i];
      // The result bit is read-only and always mirrors the live sample.
      next_ctrl_first[i][`CMPL_F1_RESULT] = next_sampled[i];
    end
    next_latch_control_zero = latch_control_zero;
    next_latch_control_one = latch_control_one;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    next_rdata = 8'h00;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `CMPL_ADDR_CMP1_CTRL_FIRST: next_ctrl_first[0] = (reg_wdata_i & `CMPL_CTRL_FIRST_WMASK)
            | {1'b0, next_sampled[0], 6'h00};
        `CMPL_ADDR_CMP1_CTRL_SECOND: next_ctrl_second[0] = reg_wdata_i & `CMPL_CTRL_SECOND_WMASK;
        `CMPL_ADDR_CMP2_CTRL_FIRST: next_ctrl_first[1] = (reg_wdata_i & `CMPL_CTRL_FIRST_WMASK)
            | {1'b0, next_sampled[1], 6'h00};
        `CMPL_ADDR_CMP2_CTRL_SECOND: next_ctrl_second[1] = reg_wdata_i & `CMPL_CTRL_SECOND_WMASK;
        `CMPL_ADDR_LATCH_CONTROL_ZERO: next_latch_control_zero = reg_wdata_i;
        `CMPL_ADDR_LATCH_CONTROL_ONE: next_latch_control_one = reg_wdata_i;
        `CMPL_ADDR_IRQ_CLEAR: next_irq_status = irq_status & ~reg_wdata_i[1:0];
        `CMPL_ADDR_IRQ_ENABLE: next_irq_enable = reg_wdata_i[1:0];
        default: ;
      endcase
    end
    // Edge detection comes after the clear, so a new edge in the clear cycle still sets the flag.
    for (int i = 0; i < NUM_CMP; i++) begin
      if ((sampled[i] & ~result_q[i] & ctrl_second[i][`CMPL_F2_RISE_IRQ])
          | (~sampled[i] & result_q[i] & ctrl_second[i][`CMPL_F2_FALL_IRQ])) begin
        next_irq_status[i] = 1'b1;
      end
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `CMPL_ADDR_CMP1_CTRL_FIRST: next_rdata = ctrl_first[0];
        `CMPL_ADDR_CMP1_CTRL_SECOND: next_rdata = ctrl_second[0];
        `CMPL_ADDR_CMP2_CTRL_FIRST: next_rdata = ctrl_first[1];
        `CMPL_ADDR_CMP2_CTRL_SECOND: next_rdata = ctrl_second[1];
        `CMPL_ADDR_OUTPUT_MIRROR: next_rdata = {6'h00, sampled};
        `CMPL_ADDR_LATCH_CONTROL_ZERO: next_rdata = latch_control_zero;
        `CMPL_ADDR_LATCH_CONTROL_ONE: next_rdata = latch_control_one;
        `CMPL_ADDR_IRQ_STATUS: next_rdata = {6'h00, irq_status};
        `CMPL_ADDR_IRQ_ENABLE: next_rdata = {6'h00, irq_enable};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Register state; the result bit of each first control register tracks the sample.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        ctrl_first[i] <= `CMPL_RST_CTRL_FIRST;
        ctrl_second[i] <= `CMPL_RST_CTRL_SECOND;
      end
      latch_control_zero <= `CMPL_RST_LATCH;
      latch_control_one <= `CMPL_RST_LATCH;
      irq_status <= `CMPL_RST_IRQ;
      irq_enable <= `CMPL_RST_IRQ;
      reg_rdata_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        ctrl_first[i] <= next_ctrl_first[i];
        ctrl_second[i] <= next_ctrl_second[i];
      end
      latch_control_zero <= next_latch_control_zero;
      latch_control_one <= next_latch_control_one;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      reg_rdata_o <= next_rdata;
      irq_o <= |(next_irq_status & next_irq_enable);
    end
  end

  // Analog control outputs straight from the control registers.
  // Taking the next values keeps the power control in step with the pin drive enable,
  // which matters when software turns a comparator off.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cmp_power_on_o <= 2'h0;
      cmp_speed_o <= 2'h3;
      cmp_hyst_o <= 2'h0;
      cmp_pch_o <= 4'h0;
      cmp_nch_o <= 4'h0;
      cmp_sampled_o <= 2'h0;
      cmp_timer_sync_o <= 2'h0;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        cmp_power_on_o[i] <= next_ctrl_first[i][`CMPL_F1_ENABLE];
        cmp_speed_o[i] <= next_ctrl_first[i][`CMPL_F1_SPEED];
        cmp_hyst_o[i] <= next_ctrl_first[i][`CMPL_F1_HYST];
        cmp_pch_o[2*i +: 2] <= next_ctrl_second[i][`CMPL_F2_PCH_LSB +: 2];
        cmp_nch_o[2*i +: 2] <= next_ctrl_second[i][`CMPL_F2_NCH_LSB +: 2];
      end
      cmp_sampled_o <= next_sampled;
      cmp_timer_sync_o <= next_tsync;
    end
  end

endmodule : cmpl_top

/* hdl/cmpl_defines.svh */
// Register offsets, field positions, reset values and timing counts of the comparator block.
`ifndef CMPL_DEFINES_SVH
`define CMPL_DEFINES_SVH
`define CMPL_ADDR_CMP1_CTRL_FIRST 4'h0
`define CMPL_ADDR_CMP1_CTRL_SECOND 4'h1
`define CMPL_ADDR_CMP2_CTRL_FIRST 4'h2
`define CMPL_ADDR_CMP2_CTRL_SECOND 4'h3
`define CMPL_ADDR_OUTPUT_MIRROR 4'h4
`define CMPL_ADDR_LATCH_CONTROL_ZERO 4'h5
`define CMPL_ADDR_LATCH_CONTROL_ONE 4'h6
`define CMPL_ADDR_IRQ_STATUS 4'h7
`define CMPL_ADDR_IRQ_CLEAR 4'h8
`define CMPL_ADDR_IRQ_ENABLE 4'h9
`define CMPL_F1_ENABLE 7
`define CMPL_F1_RESULT 6
`define CMPL_F1_PIN_OE 5
`define CMPL_F1_POLARITY 4
`define CMPL_F1_SPEED 2
`define CMPL_F1_HYST 1
`define CMPL_F1_SYNC 0
`define CMPL_F2_RISE_IRQ 7
`define CMPL_F2_FALL_IRQ 6
`define CMPL_F2_PCH_LSB 4
`define CMPL_F2_NCH_LSB 0
`define CMPL_L1_PIN_RESET 3
`define CMPL_L1_CLK_RESET 2
`define CMPL_L1_CMP2_RESET 1
`define CMPL_L1_CMP1_RESET 0
`define CMPL_RST_CTRL_FIRST 8'h04
`define CMPL_RST_CTRL_SECOND 8'h00
`define CMPL_RST_LATCH 8'h00
`define CMPL_RST_IRQ 2'h0
`define CMPL_CTRL_FIRST_WMASK 8'hB7
`define CMPL_CTRL_SECOND_WMASK 8'hF3
`define CMPL_SYNC_STAGES 3
`endif

/* hdl/cmpl_pkg.sv */
// Types shared by the comparator block.
package cmpl_pkg;
  typedef logic [7:0] cmpl_byte_t;
  typedef logic [3:0] cmpl_addr_t;
endpackage : cmpl_pkg

/* verification/cmpl_top_props.sv */
// Port-level checker of the comparator output and latch reset block.
`timescale 1ns/1ps
`include "cmpl_defines.svh"
module cmpl_top_props (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Watched inputs.
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [1:0] pin_direction_bit_i,
  input wire logic latch_peripheral_input_pin_i,
  input wire logic latch_divided_clock_i,
  // Watched outputs.
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] cmp_pin_o,
  input wire logic [1:0] cmp_pin_oe_o,
  input wire logic [1:0] cmp_power_on_o,
  input wire logic [1:0] cmp_sampled_o,
  input wire logic [1:0] cmp_timer_sync_o,
  input wire logic latch_reset_o,
  input wire logic irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [3:0] recent_src;
  logic [3:0] next_recent_src;
  logic [1:0] sync_seen, next_sync_seen, sync_q, tsync_q, exp_pin;
  // Shadow of the timer sync bits, so the pin check knows which source feeds each pin.
  always_comb begin
    next_sync_seen = sync_seen;
    if (reg_wr_i && reg_addr_i == `CMPL_ADDR_CMP1_CTRL_FIRST) begin
      next_sync_seen[0] = reg_wdata_i[`CMPL_F1_SYNC];
    end
    if (reg_wr_i && reg_addr_i == `CMPL_ADDR_CMP2_CTRL_FIRST) begin
      next_sync_seen[1] = reg_wdata_i[`CMPL_F1_SYNC];
    end
    exp_pin = (sync_q & tsync_q) | (~sync_q & cmp_sampled_o);
  end
  // Window after any reset source was high; covers the input synchronisers.
  always_comb begin
    next_recent_src = (recent_src == 4'h0) ? 4'h0 : recent_src - 4'h1;
    if (latch_peripheral_input_pin_i || latch_divided_clock_i || (|cmp_sampled_o)) begin
      next_recent_src = 4'hA;
    end
  end
  // Register the window counter and the timer sync shadows.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      recent_src <= 4'h0;
      sync_seen <= 2'h0;
      sync_q <= 2'h0;
      tsync_q <= 2'h0;
    end else begin
      recent_src <= next_recent_src;
      sync_seen <= next_sync_seen;
      sync_q <= sync_seen;
      tsync_q <= cmp_timer_sync_o;
    end
  end
  sequence s_read_mirror;
    reg_rd_i && (reg_addr_i == `CMPL_ADDR_OUTPUT_MIRROR);
  endsequence
  sequence s_dir1_held;
    pin_direction_bit_i[0] [*8];
  endsequence
  sequence s_dir2_held;
    pin_direction_bit_i[1] [*8];
  endsequence
  a_mirror_read: assert property (s_read_mirror |=>
    reg_rdata_o == {6'h00, $past(cmp_sampled_o)}) else $error("mirror read mismatch");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not idle");
  a_oe_needs_on: assert property ((cmp_pin_oe_o & ~cmp_power_on_o) == 2'b00)
    else $error("pin driven while comparator off");
  a_dir1_blocks_oe: assert property (s_dir1_held |=> !cmp_pin_oe_o[0])
    else $error("pin 1 driven as input");
  a_dir2_blocks_oe: assert property (s_dir2_held |=> !cmp_pin_oe_o[1])
    else $error("pin 2 driven as input");
  a_pin_pass: assert property ((cmp_pin_oe_o & (cmp_pin_o ^ exp_pin)) == 2'b00)
    else $error("pin differs from result");
  a_latch_cause: assert property (latch_reset_o |-> recent_src != 4'h0)
    else $error("latch reset without source");
  a_irq_rise_cause: assert property ($rose(irq_o) |-> $past(reg_wr_i) ||
    $past(reg_wr_i, 2) || ($past(cmp_sampled_o) != $past(cmp_sampled_o, 2)))
    else $error("interrupt without edge");
  a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
    else $error("interrupt dropped without write");
endmodule : cmpl_top_props
bind cmpl_top cmpl_top_props i_cmpl_top_props (.sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .pin_direction_bit_i, .latch_peripheral_input_pin_i,
  .latch_divided_clock_i, .reg_rdata_o, .cmp_pin_o, .cmp_pin_oe_o, .cmp_power_on_o,
  .cmp_sampled_o, .cmp_timer_sync_o, .latch_reset_o, .irq_o);

/* verification/cmpl_top_tb.sv */
// Self-checking bench of the comparator output and latch reset block.
`timescale 1ns/1ps
`include "cmpl_defines.svh"
module cmpl_top_tb;
  logic sys_clk_i, rst_b_i, reg_wr_i, reg_rd_i, latch_reset_o, irq_o;
  logic latch_peripheral_input_pin_i, latch_divided_clock_i;
  logic [3:0] reg_addr_i, a;
  logic [7:0] reg_wdata_i, reg_rdata_o, d, rv;
  logic [1:0] cmp_raw_i, pin_direction_bit_i, cmp_pin_o, cmp_pin_oe_o;
  logic [1:0] cmp_power_on_o, cmp_speed_o, cmp_sampled_o, cmp_hyst_o, cmp_timer_sync_o;
  logic [3:0] cmp_pch_o, cmp_nch_o;
  logic timer_clk_i;
  logic [31:0] seed;
  int n_errors, num_checks;
  localparam logic [3:0] AMAP [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
  // Device under test with every port driven or watched by the bench.
  cmpl_top i_cmpl_top (.sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .cmp_raw_i, .pin_direction_bit_i, .latch_peripheral_input_pin_i,
    .latch_divided_clock_i, .timer_clk_i, .cmp_pin_o, .cmp_pin_oe_o, .cmp_power_on_o,
    .cmp_speed_o, .cmp_hyst_o, .cmp_pch_o, .cmp_nch_o, .cmp_sampled_o,
    .cmp_timer_sync_o, .latch_reset_o, .irq_o);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Writable bits of each register; read-only bits other than the result bit must read back as zero.
  function automatic logic [7:0] wmask(input logic [3:0] x);
    if (x == 4'h0 || x == 4'h2) return `CMPL_CTRL_FIRST_WMASK;
    if (x == 4'h1 || x == 4'h3) return `CMPL_CTRL_SECOND_WMASK;
    return 8'hFF;
  endfunction : wmask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] x, input logic [7:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= x;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] x, output logic [7:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= x;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : settle
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  // Free-running system clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Main sequence.
  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    {cmp_raw_i, pin_direction_bit_i, latch_peripheral_input_pin_i, latch_divided_clock_i} = '0;
    timer_clk_i = 1'b0;
    seed = 32'hEDCB;
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    #1 chk({6'h00, cmp_speed_o}, 8'h03);
    for (int k = 0; k < 16; k++) begin
      rd(k[3:0], d);
      chk(d, (k == 0 || k == 2) ? `CMPL_RST_CTRL_FIRST : 8'h00);
    end
    $display("reset values done");
    for (int k = 0; k < 24; k++) begin
      seed = xs(seed);
      rv = seed[7:0];
      a = AMAP[seed[31:8] % 6];
      wr(a, rv);
      rd(a, d);
      chk(d & ((a == 4'h0 || a == 4'h2) ? 8'hBF : 8'hFF), rv & wmask(a));
    end
    wr(4'hB, rv);
    rd(4'hB, d);
    chk(d, 8'h00);
    for (int k = 0; k < 6; k++) wr(AMAP[k], 8'h00);
    wr(`CMPL_ADDR_IRQ_ENABLE, 8'h00);
    $display("register access done");
    // Bit 0 is the raw decision, bit 1 the polarity, bit 2 the comparator.
    for (int c = 0; c < 8; c++) begin
      cmp_raw_i <= {c[0], c[0]};
      wr(c[2] ? `CMPL_ADDR_CMP2_CTRL_FIRST : `CMPL_ADDR_CMP1_CTRL_FIRST, {3'b101, c[1], 4'h4});
      settle(12);
      chk({7'h00, cmp_sampled_o[c[2]]}, {7'h00, c[0] ^ c[1]});
      chk({6'h00, cmp_pin_oe_o[c[2]], cmp_pin_o[c[2]]}, {6'h00, 1'b1, c[0] ^ c[1]});
      rd(`CMPL_ADDR_OUTPUT_MIRROR, d);
      chk({7'h00, d[c[2]]}, {7'h00, c[0] ^ c[1]});
      rd(c[2] ? `CMPL_ADDR_CMP2_CTRL_FIRST : `CMPL_ADDR_CMP1_CTRL_FIRST, d);
      chk({7'h00, d[6]}, {7'h00, c[0] ^ c[1]});
    end
    pin_direction_bit_i <= 2'b11;
    settle(12);
    chk({6'h00, cmp_pin_oe_o}, 8'h00);
    pin_direction_bit_i <= 2'b00;
    wr(`CMPL_ADDR_CMP1_CTRL_FIRST, 8'h24);
    wr(`CMPL_ADDR_CMP2_CTRL_FIRST, 8'h34);
    settle(12);
    chk({2'h0, cmp_power_on_o, cmp_pin_oe_o, cmp_sampled_o}, 8'h02);
    $display("comparator path done");
    wr(`CMPL_ADDR_CMP1_CTRL_FIRST, 8'h84);
    wr(`CMPL_ADDR_CMP2_CTRL_FIRST, 8'h84);
    // Sources in bit order: comparator 1, comparator 2, divided clock, input pin.
    for (int k = 0; k < 4; k++) begin
      latch_peripheral_input_pin_i <= (k == 3);
      latch_divided_clock_i <= (k == 2);
      cmp_raw_i <= {k == 1, k == 0};
      wr(`CMPL_ADDR_LATCH_CONTROL_ONE, 8'h01 << k);
      settle(12);
      chk({7'h00, latch_reset_o}, 8'h01);
      wr(`CMPL_ADDR_LATCH_CONTROL_ONE, ~(8'h01 << k) & 8'h0F);
      settle(12);
      chk({7'h00, latch_reset_o}, 8'h00);
    end
    {latch_peripheral_input_pin_i, latch_divided_clock_i, cmp_raw_i} <= '0;
    $display("latch reset done");
    wr(`CMPL_ADDR_CMP1_CTRL_SECOND, 8'hC0);
    settle(12);
    wr(`CMPL_ADDR_IRQ_CLEAR, 8'h03);
    wr(`CMPL_ADDR_IRQ_ENABLE, 8'h01);
    cmp_raw_i <= 2'b01;
    settle(12);
    rd(`CMPL_ADDR_IRQ_STATUS, d);
    chk({d[6:0], irq_o}, 8'h03);
    wr(`CMPL_ADDR_IRQ_ENABLE, 8'h00);
    settle(3);
    rd(`CMPL_ADDR_IRQ_STATUS, d);
    chk({d[6:0], irq_o}, 8'h02);
    wr(`CMPL_ADDR_IRQ_CLEAR, 8'h01);
    cmp_raw_i <= 2'b00;
    rd(`CMPL_ADDR_IRQ_STATUS, d);
    chk(d, 8'h00);
    settle(12);
    wr(`CMPL_ADDR_IRQ_ENABLE, 8'h01);
    settle(3);
    rd(`CMPL_ADDR_IRQ_STATUS, d);
    chk({d[6:0], irq_o}, 8'h03);
    $display("interrupt done");
    // Timer sync, hysteresis and channel selects: the pin follows the capture, not the sample.
    wr(`CMPL_ADDR_CMP1_CTRL_SECOND, 8'h21);
    wr(`CMPL_ADDR_CMP1_CTRL_FIRST, 8'hA7);
    cmp_raw_i <= 2'b01;
    timer_clk_i <= 1'b1;
    settle(12);
    chk({cmp_pch_o, cmp_nch_o}, 8'h21);
    chk({4'h0, cmp_hyst_o, cmp_speed_o}, 8'h07);
    chk({5'h00, cmp_sampled_o[0], cmp_timer_sync_o[0], cmp_pin_o[0]}, 8'h04);
    timer_clk_i <= 1'b0;
    settle(12);
    chk({5'h00, cmp_sampled_o[0], cmp_timer_sync_o[0], cmp_pin_o[0]}, 8'h07);
    $display("timer sync done");
    close_out();
  end
endmodule : cmpl_top_tb
